// File: inc/prs_defines.svh
`ifndef PRS_DEFINES_SVH
`define PRS_DEFINES_SVH

`define PRS_ADDR_W        3
`define PRS_OFS_EVENT     3'h0
`define PRS_OFS_LOGIC     3'h1
`define PRS_OFS_SERIAL    3'h2
`define PRS_OFS_SYNC      3'h3
`define PRS_OFS_WAVE      3'h4
`define PRS_OFS_CAPT      3'h5
`define PRS_RESET_VAL     8'h00
`define PRS_MASK_EVENT    8'h03
`define PRS_MASK_LOGIC    8'h0f
`define PRS_MASK_SERIAL   8'h0f
`define PRS_MASK_SYNC     8'h03
`define PRS_MASK_WAVE     8'h3f
`define PRS_MASK_CAPT     8'h03
`define PRS_CODE_DEFAULT  2'h0
`define PRS_CODE_ALT      2'h1
`define PRS_CODE_NONE     2'h3
`define PRS_SER0_LSB      0
`define PRS_SER1_LSB      2

`endif

// File: inc/prs_pkg.sv
package prs_pkg;

	// One bit per pin of a port.
	typedef logic [7:0] prs_port_t;

	// Four-signal serial group: transmit, receive, clock, direction.
	typedef struct packed {
		logic txd;
		logic rxd;
		logic serial_clock_pin;
		logic serial_direction_pin;
	} prs_sig4_t;

	// Drive request for the pins of one port: output values and enables.
	typedef struct packed {
		prs_port_t val;
		prs_port_t oe;
	} prs_drive_t;

	// Peripheral outputs that may reach pins.
	typedef struct packed {
		logic       event_output_a;
		logic       event_output_b;
		logic [3:0] logic_table_out;
		prs_sig4_t  ser0_out;
		prs_sig4_t  ser0_oe;
		prs_sig4_t  ser1_out;
		prs_sig4_t  ser1_oe;
		prs_sig4_t  spi_out;
		prs_sig4_t  spi_oe;
		logic [5:0] waveform_output;
		logic [1:0] capture_out;
	} prs_periph_out_t;

	// Pin levels returned toward peripherals.
	typedef struct packed {
		logic [3:0][2:0] logic_table_in;
		prs_sig4_t       ser0_in;
		prs_sig4_t       ser1_in;
		prs_sig4_t       spi_in;
	} prs_periph_in_t;

	// Register file state.
	typedef struct packed {
		logic [7:0] event_output_route;
		logic [7:0] logic_table_route;
		logic [7:0] serial_port_route;
		logic [7:0] sync_serial_route;
		logic [7:0] waveform_timer_route;
		logic [7:0] capture_timer_route;
		logic [7:0] rdata;
	} prs_state_t;

endpackage

// File: core/prs_regs.sv
`timescale 1ns/1ps
`include "prs_defines.svh"

module prs_regs (
	input  wire logic                  mclk,
	input  wire logic                  sys_rst,
	input  wire logic [`PRS_ADDR_W-1:0] addr,
	input  wire logic [7:0]            wdata,
	input  wire logic                  wr_stb,
	input  wire logic                  rd_stb,
	output logic      [7:0]            rdata,
	output prs_pkg::prs_state_t        regs
);
	import prs_pkg::*;

	prs_state_t st_q;
	prs_state_t st_d;

	function automatic logic [7:0] field_mask(input logic [`PRS_ADDR_W-1:0] a);
		case (a)
			`PRS_OFS_EVENT:  field_mask = `PRS_MASK_EVENT;
			`PRS_OFS_LOGIC:  field_mask = `PRS_MASK_LOGIC;
			`PRS_OFS_SERIAL: field_mask = `PRS_MASK_SERIAL;
			`PRS_OFS_SYNC:   field_mask = `PRS_MASK_SYNC;
			`PRS_OFS_WAVE:   field_mask = `PRS_MASK_WAVE;
			`PRS_OFS_CAPT:   field_mask = `PRS_MASK_CAPT;
			default:         field_mask = 8'h00;
		endcase
	endfunction

	always_comb begin
		logic [7:0] wv;
		wv = wdata & field_mask(addr);
		st_d = st_q;
		if (wr_stb) begin
			case (addr)
				`PRS_OFS_EVENT:  st_d.event_output_route   = wv;
				`PRS_OFS_LOGIC:  st_d.logic_table_route    = wv;
				`PRS_OFS_SERIAL: st_d.serial_port_route    = wv;
				`PRS_OFS_SYNC:   st_d.sync_serial_route    = wv;
				`PRS_OFS_WAVE:   st_d.waveform_timer_route = wv;
				`PRS_OFS_CAPT:   st_d.capture_timer_route  = wv;
				default: begin
				end
			endcase
		end
		st_d.rdata = `PRS_RESET_VAL;
		if (rd_stb) begin
			case (addr)
				`PRS_OFS_EVENT:  st_d.rdata = st_q.event_output_route;
				`PRS_OFS_LOGIC:  st_d.rdata = st_q.logic_table_route;
				`PRS_OFS_SERIAL: st_d.rdata = st_q.serial_port_route;
				`PRS_OFS_SYNC:   st_d.rdata = st_q.sync_serial_route;
				`PRS_OFS_WAVE:   st_d.rdata = st_q.waveform_timer_route;
				`PRS_OFS_CAPT:   st_d.rdata = st_q.capture_timer_route;
				default:         st_d.rdata = `PRS_RESET_VAL;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata = st_q.rdata;
	assign regs  = st_q;

endmodule

// File: core/prs_pin_route_selector.sv
`timescale 1ns/1ps
`include "prs_defines.svh"

module prs_pin_route_selector (
	input  wire logic                    mclk,
	input  wire logic                    sys_rst,
	input  wire logic [`PRS_ADDR_W-1:0]   reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [7:0]              reg_rdata,
	input  wire prs_pkg::prs_periph_out_t periph_out,
	output prs_pkg::prs_periph_in_t      periph_in,
	input  wire prs_pkg::prs_port_t      pa_in,
	input  wire prs_pkg::prs_port_t      pb_in,
	input  wire prs_pkg::prs_port_t      pc_in,
	output prs_pkg::prs_drive_t          pa_ovr,
	output prs_pkg::prs_drive_t          pb_ovr,
	output prs_pkg::prs_drive_t          pc_ovr
);
	import prs_pkg::*;

	prs_state_t r;

	prs_regs u_regs (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.addr    (reg_addr),
		.wdata   (reg_wdata),
		.wr_stb  (reg_wr),
		.rd_stb  (reg_rd),
		.rdata   (reg_rdata),
		.regs    (r)
	);

	// Places one output bit on a pin of one port when the route matches and its enable is set.
	function automatic prs_drive_t place(input prs_drive_t d, input logic hit, input int unsigned pin,
	                                     input logic v, input logic oe);
		prs_drive_t o;
		o = d;
		if (hit && oe) begin
			o.val[pin] = v;
			o.oe[pin]  = 1'b1;
		end
		return o;
	endfunction

	logic [1:0] ser0_code;
	logic [1:0] ser1_code;
	logic [1:0] spi_code;

	assign ser0_code = r.serial_port_route[`PRS_SER0_LSB +: 2];
	assign ser1_code = r.serial_port_route[`PRS_SER1_LSB +: 2];
	assign spi_code  = r.sync_serial_route[1:0];

	// ********************************************************************
	// Output routing toward pins.
	// ********************************************************************
	// combinational routing
	always_comb begin
		prs_drive_t a;
		prs_drive_t b;
		prs_drive_t c;
		prs_periph_out_t p;
		logic d0;
		logic d1;
		logic s0;
		logic s1;
		logic q0;
		logic q1;
		a = '0;
		b = '0;
		c = '0;
		p = periph_out;
		// codes 2 and 3 connect nothing
		d0 = (ser0_code == `PRS_CODE_DEFAULT);
		d1 = (ser0_code == `PRS_CODE_ALT);
		s0 = (ser1_code == `PRS_CODE_DEFAULT);
		s1 = (ser1_code == `PRS_CODE_ALT);
		q0 = (spi_code == `PRS_CODE_DEFAULT);
		q1 = (spi_code == `PRS_CODE_ALT);
		b = place(b, !r.event_output_route[1], 2, p.event_output_b, 1'b1);
		b = place(b, r.event_output_route[1], 7, p.event_output_b, 1'b1);
		a = place(a, !r.event_output_route[0], 2, p.event_output_a, 1'b1);
		a = place(a, r.event_output_route[0], 7, p.event_output_a, 1'b1);
		c = place(c, !r.logic_table_route[3], 4, p.logic_table_out[3], 1'b1);
		a = place(a, r.logic_table_route[3], 5, p.logic_table_out[3], 1'b1);
		b = place(b, !r.logic_table_route[2], 3, p.logic_table_out[2], 1'b1);
		b = place(b, r.logic_table_route[2], 6, p.logic_table_out[2], 1'b1);
		a = place(a, !r.logic_table_route[1], 7, p.logic_table_out[1], 1'b1);
		c = place(c, r.logic_table_route[1], 1, p.logic_table_out[1], 1'b1);
		a = place(a, !r.logic_table_route[0], 4, p.logic_table_out[0], 1'b1);
		b = place(b, r.logic_table_route[0], 4, p.logic_table_out[0], 1'b1);
		b = place(b, d0, 2, p.ser0_out.txd, p.ser0_oe.txd);
		b = place(b, d0, 3, p.ser0_out.rxd, p.ser0_oe.rxd);
		b = place(b, d0, 1, p.ser0_out.serial_clock_pin, p.ser0_oe.serial_clock_pin);
		b = place(b, d0, 0, p.ser0_out.serial_direction_pin, p.ser0_oe.serial_direction_pin);
		a = place(a, d1, 1, p.ser0_out.txd, p.ser0_oe.txd);
		a = place(a, d1, 2, p.ser0_out.rxd, p.ser0_oe.rxd);
		a = place(a, d1, 3, p.ser0_out.serial_clock_pin, p.ser0_oe.serial_clock_pin);
		a = place(a, d1, 4, p.ser0_out.serial_direction_pin, p.ser0_oe.serial_direction_pin);
		a = place(a, s0, 1, p.ser1_out.txd, p.ser1_oe.txd);
		a = place(a, s0, 2, p.ser1_out.rxd, p.ser1_oe.rxd);
		a = place(a, s0, 3, p.ser1_out.serial_clock_pin, p.ser1_oe.serial_clock_pin);
		a = place(a, s0, 4, p.ser1_out.serial_direction_pin, p.ser1_oe.serial_direction_pin);
		c = place(c, s1, 2, p.ser1_out.txd, p.ser1_oe.txd);
		c = place(c, s1, 1, p.ser1_out.rxd, p.ser1_oe.rxd);
		c = place(c, s1, 0, p.ser1_out.serial_clock_pin, p.ser1_oe.serial_clock_pin);
		c = place(c, s1, 3, p.ser1_out.serial_direction_pin, p.ser1_oe.serial_direction_pin);
		a = place(a, q0, 1, p.spi_out.txd, p.spi_oe.txd);
		a = place(a, q0, 2, p.spi_out.rxd, p.spi_oe.rxd);
		a = place(a, q0, 3, p.spi_out.serial_clock_pin, p.spi_oe.serial_clock_pin);
		a = place(a, q0, 4, p.spi_out.serial_direction_pin, p.spi_oe.serial_direction_pin);
		c = place(c, q1, 2, p.spi_out.txd, p.spi_oe.txd);
		c = place(c, q1, 1, p.spi_out.rxd, p.spi_oe.rxd);
		c = place(c, q1, 0, p.spi_out.serial_clock_pin, p.spi_oe.serial_clock_pin);
		c = place(c, q1, 3, p.spi_out.serial_direction_pin, p.spi_oe.serial_direction_pin);
		for (int i = 0; i < 3; i++) begin
			b = place(b, !r.waveform_timer_route[i], i, p.waveform_output[i], 1'b1);
			b = place(b, r.waveform_timer_route[i], i + 3, p.waveform_output[i], 1'b1);
		end
		for (int i = 3; i < 6; i++) begin
			a = place(a, !r.waveform_timer_route[i], i, p.waveform_output[i], 1'b1);
			c = place(c, r.waveform_timer_route[i], i, p.waveform_output[i], 1'b1);
		end
		a = place(a, !r.capture_timer_route[1], 3, p.capture_out[1], 1'b1);
		c = place(c, r.capture_timer_route[1], 4, p.capture_out[1], 1'b1);
		a = place(a, !r.capture_timer_route[0], 5, p.capture_out[0], 1'b1);
		c = place(c, r.capture_timer_route[0], 0, p.capture_out[0], 1'b1);
		pa_ovr = a;
		pb_ovr = b;
		pc_ovr = c;
	end

	// ********************************************************************
	// Input routing toward peripherals.
	// ********************************************************************
	// connect or disconnect inputs
	always_comb begin
		periph_in = '0;
		periph_in.logic_table_in[0] = pa_in[2:0];
		periph_in.logic_table_in[1] = pc_in[5:3];
		periph_in.logic_table_in[2] = pb_in[2:0];
		periph_in.logic_table_in[3] = pc_in[2:0];
		case (ser0_code)
			`PRS_CODE_DEFAULT: periph_in.ser0_in = {pb_in[2], pb_in[3], pb_in[1], pb_in[0]};
			`PRS_CODE_ALT:     periph_in.ser0_in = {pa_in[1], pa_in[2], pa_in[3], pa_in[4]};
			default:           periph_in.ser0_in = '0;
		endcase
		case (ser1_code)
			`PRS_CODE_DEFAULT: periph_in.ser1_in = {pa_in[1], pa_in[2], pa_in[3], pa_in[4]};
			`PRS_CODE_ALT:     periph_in.ser1_in = {pc_in[2], pc_in[1], pc_in[0], pc_in[3]};
			default:           periph_in.ser1_in = '0;
		endcase
		case (spi_code)
			`PRS_CODE_DEFAULT: periph_in.spi_in = {pa_in[1], pa_in[2], pa_in[3], pa_in[4]};
			`PRS_CODE_ALT:     periph_in.spi_in = {pc_in[2], pc_in[1], pc_in[0], pc_in[3]};
			default:           periph_in.spi_in = '0;
		endcase
	end

endmodule

// File: test/prs_route_assertions.sv
`timescale 1ns/1ps
`include "prs_defines.svh"
// ****************
// Routing checker.
// ****************
module prs_checker
	import prs_pkg::*;
(
	input wire logic                    mclk,
	input wire logic                    sys_rst,
	input wire logic [`PRS_ADDR_W-1:0]  reg_addr,
	input wire logic [7:0]              reg_wdata,
	input wire logic                    reg_wr,
	input wire logic                    reg_rd,
	input wire logic [7:0]              reg_rdata,
	input wire prs_pkg::prs_periph_out_t periph_out,
	input wire prs_pkg::prs_periph_in_t  periph_in,
	input wire prs_pkg::prs_port_t       pa_in,
	input wire prs_pkg::prs_port_t       pb_in,
	input wire prs_pkg::prs_port_t       pc_in,
	input wire prs_pkg::prs_drive_t      pa_ovr,
	input wire prs_pkg::prs_drive_t      pb_ovr,
	input wire prs_pkg::prs_drive_t      pc_ovr
);
	logic [7:0] sr_q;
	logic [7:0] wv_q;
	logic [7:0] cb_q;

	// Shadow copies of the serial, waveform and capture routing fields, rebuilt from the bus alone.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sr_q <= 8'h00;
			wv_q <= 8'h00;
			cb_q <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == `PRS_OFS_SERIAL) sr_q <= reg_wdata;
			if (reg_addr == `PRS_OFS_WAVE) wv_q <= reg_wdata;
			if (reg_addr == `PRS_OFS_CAPT) cb_q <= reg_wdata;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_wave_wr;
		reg_wr && reg_addr == `PRS_OFS_WAVE;
	endsequence

	a_wave_readback: assert property (s_wave_wr ##1 (reg_rd && reg_addr == `PRS_OFS_WAVE)
		|=> reg_rdata == ($past(reg_wdata, 2) & `PRS_MASK_WAVE)) else $error("waveform readback wrong");
	a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
	a_unmapped_zero: assert property (reg_rd && reg_addr > `PRS_OFS_CAPT |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_wave_dflt: assert property (!wv_q[0] |-> pb_ovr.oe[0] && pb_ovr.val[0] == periph_out.waveform_output[0])
		else $error("waveform 0 default wrong");
	a_wave_alt: assert property (wv_q[5] |-> pc_ovr.oe[5] && pc_ovr.val[5] == periph_out.waveform_output[5])
		else $error("waveform 5 alternate wrong");
	a_capt_alt: assert property (cb_q[0] |-> pc_ovr.oe[0] && pc_ovr.val[0] == periph_out.capture_out[0])
		else $error("capture 0 alternate wrong");
	a_capt_dflt: assert property (!cb_q[1] |-> pa_ovr.oe[3] && pa_ovr.val[3] == periph_out.capture_out[1])
		else $error("capture 1 default wrong");
	a_serial_off: assert property (sr_q[1] |-> periph_in.ser0_in == 4'h0) else $error("serial not cut off");
	a_serial_rx: assert property (sr_q[1:0] == 2'h0 |-> periph_in.ser0_in.rxd == pb_in[3])
		else $error("serial receive pin wrong");
	a_table_inputs: assert property (periph_in.logic_table_in[0] == pa_in[2:0]
		&& periph_in.logic_table_in[1] == pc_in[5:3]) else $error("table inputs wrong");
endmodule

bind prs_pin_route_selector prs_checker u_prs_checker (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .periph_out, .periph_in, .pa_in, .pb_in, .pc_in, .pa_ovr, .pb_ovr, .pc_ovr);

// File: test/prs_periph_model.sv
`timescale 1ns/1ps
// ******************************
// Peripheral and pin-level model.
// ******************************
module prs_periph_model
	import prs_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                sys_rst,
	output prs_pkg::prs_periph_out_t periph_out,
	output prs_pkg::prs_port_t       pa_in,
	output prs_pkg::prs_port_t       pb_in,
	output prs_pkg::prs_port_t       pc_in
);
	logic [7:0] cnt_q;

	// Levels come from a counter stepped by 8'h3b each cycle, so a stale or swapped pin is unlikely to match by luck.
	always_ff @(posedge mclk) begin
		cnt_q <= sys_rst ? 8'h5a : cnt_q + 8'h3b;
	end
	assign periph_out = {cnt_q[5:0], {4{cnt_q}}};
	assign pa_in = cnt_q ^ 8'hc3;
	assign pb_in = ~cnt_q;
	assign pc_in = {cnt_q[3:0], cnt_q[7:4]};
endmodule

// File: test/prs_pin_route_selector_tb.sv
`timescale 1ns/1ps
`include "prs_defines.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; $display("wrong value %0t %h %h", $time, g, e); end end
// *****************
// Routing testbench.
// *****************
module prs_pin_route_selector_tb;
	import prs_pkg::*;
	logic            mclk = 1'b0;
	logic            sys_rst = 1'b1;
	logic [2:0]      reg_addr = 3'h0;
	logic [7:0]      reg_wdata = 8'h00;
	logic [7:0]      reg_rdata;
	logic            reg_wr = 1'b0;
	logic            reg_rd = 1'b0;
	prs_periph_out_t periph_out;
	prs_periph_in_t  periph_in;
	prs_port_t       pa_in, pb_in, pc_in;
	prs_drive_t      pa_ovr, pb_ovr, pc_ovr;
	int              err_total = 0;
	int              check_count = 0;

	always #12.5 mclk = ~mclk;

	prs_pin_route_selector u_prs_pin_route_selector (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .periph_out, .periph_in, .pa_in, .pb_in, .pc_in, .pa_ovr, .pb_ovr, .pc_ovr);
	prs_periph_model u_prs_periph_model (.mclk, .sys_rst, .periph_out, .pa_in, .pb_in, .pc_in);

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		`CHK(reg_rdata, e)
		@(posedge mclk);
	endtask

	task automatic wr_rd(input logic [2:0] a, input logic [7:0] d, input logic [7:0] e);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		`CHK(reg_rdata, e)
		@(posedge mclk);
	endtask

	task automatic t_regs();
		logic [7:0] m [8];
		m = '{`PRS_MASK_EVENT, `PRS_MASK_LOGIC, `PRS_MASK_SERIAL, `PRS_MASK_SYNC, `PRS_MASK_WAVE, `PRS_MASK_CAPT,
			8'h00, 8'h00};
		for (int i = 0; i < 8; i++) begin
			rd(i[2:0], `PRS_RESET_VAL);
			wr(i[2:0], 8'hff);
			rd(i[2:0], m[i]);
		end
		wr_rd(`PRS_OFS_WAVE, 8'hff, `PRS_MASK_WAVE);
	endtask

	task automatic t_event();
		for (int v = 0; v < 4; v++) begin
			wr(`PRS_OFS_EVENT, v[7:0]);
			@(negedge mclk);
			`CHK(pa_ovr.val[v[0] ? 7 : 2], periph_out.event_output_a)
			`CHK({pa_ovr.oe[7], pa_ovr.oe[2]}, {v[0], ~v[0]})
			`CHK(pb_ovr.val[v[1] ? 7 : 2], periph_out.event_output_b)
			`CHK({pb_ovr.oe[7], pb_ovr.oe[2]}, {v[1], ~v[1]})
		end
		wr(`PRS_OFS_LOGIC, 8'h0d);
		@(negedge mclk);
		`CHK(pa_ovr.val[7], periph_out.logic_table_out[1])
		`CHK({periph_in.logic_table_in[3], periph_in.logic_table_in[2]}, {pc_in[2:0], pb_in[2:0]})
	endtask

	task automatic t_serial();
		logic [1:0] txd_pin;
		for (int c = 0; c < 4; c += (c == 1) ? 2 : 1) begin
			wr(`PRS_OFS_SERIAL, 8'(c * 5));
			wr(`PRS_OFS_SYNC, 8'(c));
			@(negedge mclk);
			if (c >= 2) begin
				`CHK({periph_in.ser0_in, periph_in.ser1_in, periph_in.spi_in}, 12'h000)
			end else begin
				`CHK(periph_in.ser0_in.rxd, c ? pa_in[2] : pb_in[3])
				`CHK(periph_in.ser0_in.serial_clock_pin, c ? pa_in[3] : pb_in[1])
				txd_pin = c ? {pa_ovr.oe[1], pa_ovr.val[1]} : {pb_ovr.oe[2], pb_ovr.val[2]};
				`CHK(txd_pin, {periph_out.ser0_oe.txd, periph_out.ser0_out.txd & periph_out.ser0_oe.txd})
				`CHK(periph_in.ser1_in.rxd, c ? pc_in[1] : pa_in[2])
				`CHK(periph_in.spi_in.rxd, c ? pc_in[1] : pa_in[2])
			end
		end
		`CHK({pa_ovr.val[1], pa_ovr.oe[1]}, 2'h0)
	endtask

	task automatic t_wave();
		wr(`PRS_OFS_CAPT, 8'h03);
		wr(`PRS_OFS_WAVE, 8'h00);
		@(negedge mclk);
		`CHK({pa_ovr.val[5:3], pb_ovr.val[2:0]}, periph_out.waveform_output)
		`CHK({pc_ovr.val[4], pc_ovr.val[0]}, periph_out.capture_out)
		wr(`PRS_OFS_CAPT, 8'h00);
		wr(`PRS_OFS_WAVE, 8'h3f);
		@(negedge mclk);
		`CHK({pc_ovr.val[5:3], pb_ovr.val[5:3]}, periph_out.waveform_output)
		`CHK({pa_ovr.val[3], pa_ovr.val[5]}, periph_out.capture_out)
		wr(`PRS_OFS_WAVE, 8'h2a);
		@(negedge mclk);
		`CHK({pc_ovr.val[5], pa_ovr.val[4], pc_ovr.val[3], pb_ovr.val[2], pb_ovr.val[4], pb_ovr.val[0]},
			periph_out.waveform_output)
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (2000) @(posedge mclk);
		err_total++;
		tally_and_finish();
	end

	initial begin
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		t_regs();
		t_event();
		t_serial();
		t_wave();
		tally_and_finish();
	end
endmodule
